// ==== bidir_fifo_consts.vh ====
// Constants for the bidirectional FIFO flag and mailbox block
`ifndef BIDIR_FIFO_CONSTS_VH
`define BIDIR_FIFO_CONSTS_VH

// Queue geometry
`define FIFO_DEPTH 10'h100
`define PTR_W 9
`define ADDR_W 8
`define DATA_W 36

// Bus size codes for the port B width
`define SIZE_LONG 2'h0
`define SIZE_WORD 2'h1
`define SIZE_BYTE 2'h2

// Mailbox lane masks per bus size
`define MASK_LONG 36'hf_ffff_ffff
`define MASK_WORD 36'h0_0003_ffff
`define MASK_BYTE 36'h0_0000_01ff

// Register byte addresses
`define REG_CTRL 12'h000
`define REG_OFFSETS 12'h004
`define REG_STATUS 12'h008
`define REG_FILL 12'h00c

// Field positions
`define CTRL_FALLTHROUGH_BIT 0
`define CTRL_SIZE_LSB 1
`define OFS_FIFO1_LOW_LSB 0
`define OFS_FIFO1_HIGH_LSB 8
`define OFS_FIFO2_LOW_LSB 16
`define OFS_FIFO2_HIGH_LSB 24

// Reset values
`define CTRL_RESET 3'h0
`define OFFSET_RESET 8'h08

`endif

// ==== bidir_fifo_flags_mailbox.v ====
// Bidirectional FIFO pair with write-room, near-empty, near-full flags and mailboxes
// What this block does
// - Write-room output serves as input-ready or active-low full, by timing mode.
// - High means a free location; low means full and FIFO writes are dropped.
// - Write-room follows the writing port clock; write pointer steps per accepted word.
// - After a read frees space, write-room rises on the second writing clock edge.
// - A writing edge too close to the read does not count as first sync edge.
// - Near-empty follows reading clock; low at X or fewer words, high above.
// - Port B near-empty uses first FIFO low offset; port A uses second FIFO's.
// - A word moved to the output register no longer counts as stored.
// - Near-empty rises on the second reading edge after the fill reaches X+1.
// - Near-full follows writing clock; low at depth minus Y words or more.
// - Port A near-full uses first FIFO high offset; port B uses second FIFO's.
// - Near-full rises on the second writing edge after the fill drops enough.
// - Each direction has a 36-bit mailbox chosen by the port's mail pick input.
// - Port A mail write loads the A-to-B mailbox on lanes allowed by bus size.
// - Port B mail write loads the B-to-A mailbox on lanes allowed by bus size.
// - A mailbox write drives its pending flag low; further writes are then dropped.
// - Enabled port outputs show the FIFO output register or mailbox by mail pick.
// - Port B mail read sets the A-to-B pending flag high; data on B lanes.
// - Port A mail read sets the B-to-A pending flag high; data on A lanes.
// - Mailbox data survives reads and is never reordered by byte ordering.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bidir_fifo_consts.vh"

module bidir_fifo_flags_mailbox (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // APB register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Port A
  input wire port_a_clock,
  input wire port_a_select_n,
  input wire port_a_direction,
  input wire port_a_transfer_qualifier,
  input wire port_a_mail_pick,
  input wire [35:0] port_a_data_in,
  output reg [35:0] port_a_data_out,
  output wire port_a_data_oe,
  // Port B
  input wire port_b_clock,
  input wire port_b_select_n,
  input wire port_b_direction,
  input wire port_b_transfer_qualifier,
  input wire port_b_mail_pick,
  input wire [35:0] port_b_data_in,
  output reg [35:0] port_b_data_out,
  output wire port_b_data_oe,
  // Flags
  output wire port_a_write_room_flag,
  output wire port_b_write_room_flag,
  output wire port_a_near_empty_n,
  output wire port_b_near_empty_n,
  output wire port_a_near_full_n,
  output wire port_b_near_full_n,
  output wire mail_to_b_pending_n,
  output wire mail_to_a_pending_n
);

  function [`PTR_W-1:0] gray_to_bin;
    input [`PTR_W-1:0] g;
    integer i;
    begin
      gray_to_bin[`PTR_W-1] = g[`PTR_W-1];
      for (i = `PTR_W-2; i >= 0; i = i - 1) begin
        gray_to_bin[i] = gray_to_bin[i+1] ^ g[i];
      end
    end
  endfunction

  function [35:0] lane_mask;
    input [1:0] size;
    begin
      case (size)
        `SIZE_WORD: lane_mask = `MASK_WORD;
        `SIZE_BYTE: lane_mask = `MASK_BYTE;
        default: lane_mask = `MASK_LONG;
      endcase
    end
  endfunction

  // Configuration registers
  reg [2:0] ctrl_q;
  reg [31:0] offsets_q;
  wire first_word_fallthrough = ctrl_q[`CTRL_FALLTHROUGH_BIT];
  wire [1:0] bus_match_select = ctrl_q[`CTRL_SIZE_LSB+1:`CTRL_SIZE_LSB];
  wire [35:0] mask = lane_mask(bus_match_select);

  // Port clocks arrive as ordinary synchronous inputs; act on their rising edges
  // Each port clock level must last a core cycle, or its edges are missed
  reg a_clk_q;
  reg b_clk_q;
  wire a_rise = port_a_clock & ~a_clk_q;
  wire b_rise = port_b_clock & ~b_clk_q;
  wire a_sel = a_rise & ~port_a_select_n & port_a_transfer_qualifier;
  wire b_sel = b_rise & ~port_b_select_n & port_b_transfer_qualifier;
  wire a_wr = a_sel & port_a_direction;
  wire a_rd = a_sel & ~port_a_direction;
  wire b_wr = b_sel & ~port_b_direction;
  wire b_rd = b_sel & port_b_direction;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      // Reset high so a port clock already high at release is no edge
      a_clk_q <= 1'b1;
      b_clk_q <= 1'b1;
    end else begin
      a_clk_q <= port_a_clock;
      b_clk_q <= port_b_clock;
    end
  end

  // Index 0 is the A-to-B queue, index 1 the B-to-A queue
  wire [1:0] wr_edge = {b_rise, a_rise};
  wire [1:0] rd_edge = {a_rise, b_rise};
  wire [1:0] wr_req = {b_wr & ~port_b_mail_pick, a_wr & ~port_a_mail_pick};
  wire [1:0] rd_req = {a_rd & ~port_a_mail_pick, b_rd & ~port_b_mail_pick};
  wire [71:0] wr_data = {port_b_data_in, port_a_data_in};
  wire [15:0] low_ofs = {offsets_q[`OFS_FIFO2_LOW_LSB+7:`OFS_FIFO2_LOW_LSB],
                         offsets_q[`OFS_FIFO1_LOW_LSB+7:`OFS_FIFO1_LOW_LSB]};
  wire [15:0] high_ofs = {offsets_q[`OFS_FIFO2_HIGH_LSB+7:`OFS_FIFO2_HIGH_LSB],
                          offsets_q[`OFS_FIFO1_HIGH_LSB+7:`OFS_FIFO1_HIGH_LSB]};
  wire [1:0] room;
  wire [1:0] near_empty_n;
  wire [1:0] near_full_n;
  wire [17:0] fill_w;
  wire [71:0] out_reg;

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : queue
      reg [35:0] mem [0:`FIFO_DEPTH-1];
      reg [`PTR_W-1:0] wbin_q;
      reg [`PTR_W-1:0] rbin_q;
      reg [`PTR_W-1:0] wgray_s1_q;
      reg [`PTR_W-1:0] wgray_s2_q;
      reg [`PTR_W-1:0] rgray_s1_q;
      reg [`PTR_W-1:0] rgray_s2_q;
      reg [35:0] oreg_q;
      reg ovalid_q;
      wire [`PTR_W-1:0] wgray = wbin_q ^ (wbin_q >> 1);
      wire [`PTR_W-1:0] rgray = rbin_q ^ (rbin_q >> 1);
      // Write side sees the read pointer only after two writing-clock edges
      wire [`PTR_W-1:0] cnt_w = wbin_q - gray_to_bin(rgray_s2_q);
      // Read side sees the write pointer only after two reading-clock edges
      wire [`PTR_W-1:0] cnt_r = gray_to_bin(wgray_s2_q) - rbin_q;
      wire has_room = ({1'b0, cnt_w} != `FIFO_DEPTH);
      wire wr_ok = wr_req[d] & has_room;
      wire has_word = (cnt_r != {`PTR_W{1'b0}});
      // Fall-through shifts only on a reading edge, like a requested read
      wire auto_load = first_word_fallthrough & ~ovalid_q & rd_edge[d];
      wire load = has_word & (rd_req[d] | auto_load);

      assign room[d] = has_room;
      assign near_empty_n[d] = (cnt_r > {1'b0, low_ofs[d*8 +: 8]});
      assign near_full_n[d] = (({1'b0, cnt_w} + {2'h0, high_ofs[d*8 +: 8]})
                              < `FIFO_DEPTH);
      assign fill_w[d*9 +: 9] = cnt_w;
      assign out_reg[d*36 +: 36] = oreg_q;

      always @(posedge core_clk) begin
        if (wr_ok) begin
          mem[wbin_q[`ADDR_W-1:0]] <= wr_data[d*36 +: 36];
        end
      end

      always @(posedge core_clk) begin
        if (!rst_b) begin
          wbin_q <= {`PTR_W{1'b0}};
          rbin_q <= {`PTR_W{1'b0}};
          wgray_s1_q <= {`PTR_W{1'b0}};
          wgray_s2_q <= {`PTR_W{1'b0}};
          rgray_s1_q <= {`PTR_W{1'b0}};
          rgray_s2_q <= {`PTR_W{1'b0}};
          oreg_q <= 36'h0_0000_0000;
          ovalid_q <= 1'b0;
        end else begin
          if (wr_ok) begin
            wbin_q <= wbin_q + 1'b1;
          end
          // Edge in the same cycle as a read captures the old pointer
          if (wr_edge[d]) begin
            rgray_s1_q <= rgray;
            rgray_s2_q <= rgray_s1_q;
          end
          if (rd_edge[d]) begin
            wgray_s1_q <= wgray;
            wgray_s2_q <= wgray_s1_q;
          end
          if (load) begin
            oreg_q <= mem[rbin_q[`ADDR_W-1:0]];
            rbin_q <= rbin_q + 1'b1;
            ovalid_q <= 1'b1;
          end else if (rd_req[d]) begin
            ovalid_q <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign port_a_write_room_flag = room[0];
  assign port_b_write_room_flag = room[1];
  assign port_b_near_empty_n = near_empty_n[0];
  assign port_a_near_empty_n = near_empty_n[1];
  assign port_a_near_full_n = near_full_n[0];
  assign port_b_near_full_n = near_full_n[1];

  // Mailboxes
  reg [35:0] mailbox_a_to_b;
  reg [35:0] mailbox_b_to_a;
  reg mail_ab_full_q;
  reg mail_ba_full_q;
  wire mail_ab_wr = a_wr & port_a_mail_pick & ~mail_ab_full_q;
  wire mail_ba_wr = b_wr & port_b_mail_pick & ~mail_ba_full_q;
  wire mail_ab_rd = b_rd & port_b_mail_pick;
  wire mail_ba_rd = a_rd & port_a_mail_pick;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      mailbox_a_to_b <= 36'h0_0000_0000;
      mailbox_b_to_a <= 36'h0_0000_0000;
      mail_ab_full_q <= 1'b0;
      mail_ba_full_q <= 1'b0;
    end else begin
      // Reads leave contents alone; no byte reordering on this path
      if (mail_ab_wr) begin
        mailbox_a_to_b <= port_a_data_in & mask;
      end
      if (mail_ba_wr) begin
        mailbox_b_to_a <= port_b_data_in & mask;
      end
      // Clear first so a write in the same cycle wins
      if (mail_ab_rd) begin
        mail_ab_full_q <= 1'b0;
      end
      if (mail_ab_wr) begin
        mail_ab_full_q <= 1'b1;
      end
      if (mail_ba_rd) begin
        mail_ba_full_q <= 1'b0;
      end
      if (mail_ba_wr) begin
        mail_ba_full_q <= 1'b1;
      end
    end
  end

  assign mail_to_b_pending_n = ~mail_ab_full_q;
  assign mail_to_a_pending_n = ~mail_ba_full_q;

  // Port data outputs; unused mailbox lanes read as zero
  assign port_a_data_oe = ~port_a_select_n & ~port_a_direction;
  assign port_b_data_oe = ~port_b_select_n & port_b_direction;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      port_a_data_out <= 36'h0_0000_0000;
      port_b_data_out <= 36'h0_0000_0000;
    end else begin
      port_a_data_out <= port_a_mail_pick ? (mailbox_b_to_a & mask)
                                          : out_reg[71:36];
      port_b_data_out <= port_b_mail_pick ? (mailbox_a_to_b & mask)
                                          : out_reg[35:0];
    end
  end

  // APB slave: zero wait states, read data latched in the setup cycle
  wire setup = psel & ~penable;
  wire mapped = (paddr == `REG_CTRL) | (paddr == `REG_OFFSETS) |
                (paddr == `REG_STATUS) | (paddr == `REG_FILL);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_q <= `CTRL_RESET;
      offsets_q <= {4{`OFFSET_RESET}};
      prdata <= 32'h0000_0000;
    end else begin
      if (psel & penable & pwrite) begin
        if (paddr == `REG_CTRL) begin
          ctrl_q <= pwdata[2:0];
        end
        if (paddr == `REG_OFFSETS) begin
          offsets_q <= pwdata;
        end
      end
      if (setup) begin
        case (paddr)
          `REG_CTRL: prdata <= {29'h0000_0000, ctrl_q};
          `REG_OFFSETS: prdata <= offsets_q;
          `REG_STATUS: prdata <= {24'h00_0000, mail_to_a_pending_n, mail_to_b_pending_n,
                                  near_full_n, near_empty_n, room};
          `REG_FILL: prdata <= {7'h00, fill_w[17:9], 7'h00, fill_w[8:0]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // bidir_fifo_flags_mailbox
`default_nettype wire

// ==== bidir_fifo_flags_mailbox_chk.sv ====
// Port-level assertions for the FIFO flag and mailbox block
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_flags_mailbox_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Port A controls
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_transfer_qualifier,
  input wire logic port_a_mail_pick,
  // Port B controls and data
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_direction,
  input wire logic port_b_transfer_qualifier,
  input wire logic port_b_mail_pick,
  input wire logic [35:0] port_b_data_out,
  // Flags
  input wire logic port_a_write_room_flag,
  input wire logic port_a_near_full_n,
  input wire logic port_b_near_empty_n,
  input wire logic mail_to_b_pending_n,
  input wire logic mail_to_a_pending_n
);
  logic a_q;
  logic b_q;
  // Start high so a port clock high at release is no edge
  always_ff @(posedge core_clk) begin
    a_q <= rst_b ? port_a_clock : 1'b1;
    b_q <= rst_b ? port_b_clock : 1'b1;
  end
  wire logic a_e = port_a_clock && !a_q;
  wire logic b_e = port_b_clock && !b_q;
  wire logic a_mb = a_e && !port_a_select_n && port_a_transfer_qualifier && port_a_mail_pick;
  wire logic b_mb = b_e && !port_b_select_n && port_b_transfer_qualifier && port_b_mail_pick;
  wire logic a_mw = a_mb && port_a_direction;
  wire logic a_mr = a_mb && !port_a_direction;
  wire logic b_mw = b_mb && !port_b_direction;
  wire logic b_mr = b_mb && port_b_direction;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_mail_a_load: assert property (
    a_mw && mail_to_b_pending_n && !b_mr |=> !mail_to_b_pending_n)
    else $error("mail to B flag stayed high");
  chk_mail_b_load: assert property (
    b_mw && mail_to_a_pending_n && !a_mr |=> !mail_to_a_pending_n)
    else $error("mail to A flag stayed high");
  chk_mail_b_take: assert property (
    b_mr && !(a_mw && mail_to_b_pending_n) |=> mail_to_b_pending_n)
    else $error("mail to B flag not released");
  chk_mail_a_take: assert property (
    a_mr && !(b_mw && mail_to_a_pending_n) |=> mail_to_a_pending_n)
    else $error("mail to A flag not released");
  chk_mail_held: assert property (
    !mail_to_b_pending_n && !b_mr |=> !mail_to_b_pending_n)
    else $error("mail to B flag rose without a read");
  chk_mail_data_keep: assert property (
    (port_b_mail_pick && !a_mw) [*3] |-> $stable(port_b_data_out))
    else $error("mailbox output moved without a write");
  chk_full_near_full: assert property (
    !port_a_write_room_flag |-> !port_a_near_full_n)
    else $error("full without near full");
  chk_room_on_edge: assert property (
    $changed(port_a_write_room_flag) |-> $past(a_e))
    else $error("room flag moved off a writing edge");
  chk_empty_on_edge: assert property (
    $changed(port_b_near_empty_n) |-> $past(b_e))
    else $error("near empty moved off a reading edge");
  chk_full_on_edge: assert property (
    $changed(port_a_near_full_n) |-> $past(a_e))
    else $error("near full moved off a writing edge");
  cover property (a_mw);
  cover property (b_mr);
  cover property ($fell(port_a_write_room_flag));
endmodule // bidir_fifo_flags_mailbox_chk

bind bidir_fifo_flags_mailbox bidir_fifo_flags_mailbox_chk u_chk (
  .core_clk, .rst_b, .port_a_clock, .port_a_select_n, .port_a_direction,
  .port_a_transfer_qualifier, .port_a_mail_pick, .port_b_clock, .port_b_select_n,
  .port_b_direction, .port_b_transfer_qualifier, .port_b_mail_pick, .port_b_data_out,
  .port_a_write_room_flag, .port_a_near_full_n, .port_b_near_empty_n,
  .mail_to_b_pending_n, .mail_to_a_pending_n);
`default_nettype wire

// ==== port_host.sv ====
// Host model for one FIFO port: free-running port clock and transfers
`timescale 1ns/1ps
`default_nettype none
module port_host #(
  parameter int HALF = 1
) (
  // Core clock
  input wire logic core_clk,
  // Port pins
  output logic pclk,
  output logic sel_n,
  output logic dir,
  output logic qual,
  output logic pick,
  output logic [35:0] dat
);
  int cnt = 0;
  initial begin
    pclk = 1'b0;
    sel_n = 1'b1;
    dir = 1'b0;
    qual = 1'b0;
    pick = 1'b0;
    dat = 36'h0;
  end
  // Larger HALF gives a slow host
  always @(posedge core_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) pclk <= ~pclk;
  end
  // Held across one rising port edge; released data shows its inverse
  task automatic op(input logic wr, input logic mp, input logic [35:0] d);
    @(posedge core_clk iff !pclk);
    sel_n <= 1'b0;
    qual <= 1'b1;
    dir <= wr;
    pick <= mp;
    dat <= d;
    @(posedge core_clk iff pclk);
    sel_n <= 1'b1;
    qual <= 1'b0;
    dat <= ~d;
  endtask
endmodule // port_host
`default_nettype wire

// ==== bidir_fifo_flags_mailbox_tb.sv ====
// Self-checking testbench for the FIFO flag and mailbox block
`timescale 1ns/1ps
`default_nettype none
`include "bidir_fifo_consts.vh"
module bidir_fifo_flags_mailbox_tb;
  localparam int fifo1_high_water_offset = 4;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, a_clk, a_sel_n, a_dir, a_qual, a_pick;
  wire logic b_clk, b_sel_n, b_dir, b_qual, b_pick;
  wire logic [35:0] a_din, b_din, a_dout, b_dout;
  wire logic [7:0] flg;
  logic [35:0] exp_q[$];
  logic [35:0] d, base;
  int n_fail = 0, n_checks = 0;
  always #4 core_clk = ~core_clk;
  port_host #(.HALF(1)) pa (.core_clk(core_clk), .pclk(a_clk), .sel_n(a_sel_n), .dir(a_dir),
    .qual(a_qual), .pick(a_pick), .dat(a_din));
  port_host #(.HALF(3)) pb (.core_clk(core_clk), .pclk(b_clk), .sel_n(b_sel_n), .dir(b_dir),
    .qual(b_qual), .pick(b_pick), .dat(b_din));
  bidir_fifo_flags_mailbox dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_clock(a_clk), .port_a_select_n(a_sel_n),
    .port_a_direction(a_dir), .port_a_transfer_qualifier(a_qual), .port_a_mail_pick(a_pick),
    .port_a_data_in(a_din), .port_a_data_out(a_dout), .port_a_data_oe(),
    .port_b_clock(b_clk), .port_b_select_n(b_sel_n), .port_b_direction(b_dir),
    .port_b_transfer_qualifier(b_qual), .port_b_mail_pick(b_pick), .port_b_data_in(b_din),
    .port_b_data_out(b_dout), .port_b_data_oe(), .port_a_write_room_flag(flg[0]),
    .port_b_write_room_flag(flg[1]), .port_a_near_empty_n(flg[3]),
    .port_b_near_empty_n(flg[2]), .port_a_near_full_n(flg[4]), .port_b_near_full_n(flg[5]),
    .mail_to_b_pending_n(flg[6]), .mail_to_a_pending_n(flg[7]));
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [35:0] e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    if (!wr) exp_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      cmp({3'h0, pslverr, prdata}, exp_q.pop_front());
  // Flag word for c words in the A-to-B queue, other queue empty
  function automatic logic [7:0] st(input int c);
    return {3'b111, c < `FIFO_DEPTH - fifo1_high_water_offset, 1'b0, c > 2, 1'b1,
            c < `FIFO_DEPTH};
  endfunction
  // Waits out two slow-port sync edges before looking
  task automatic chk_st(input int c);
    repeat (24) @(posedge core_clk);
    apb(1'b0, `REG_STATUS, 32'h0, {28'h0, st(c)});
    apb(1'b0, `REG_FILL, 32'h0, 36'(c));
    @(negedge core_clk);
    cmp(36'(flg), 36'(st(c)));
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hc299af7c));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0, {33'h0, `CTRL_RESET});
    apb(1'b0, `REG_OFFSETS, 32'h0, 36'({4{`OFFSET_RESET}}));
    apb(1'b1, `REG_STATUS, 32'h0, 36'h0);
    chk_st(0);
    apb(1'b0, 12'h010, 32'h0, 36'h1_0000_0000);
    apb(1'b1, `REG_CTRL, 32'h2, 36'h0);
    apb(1'b1, `REG_OFFSETS, 32'h0808_0402, 36'h0);
    d = 36'({$urandom(), $urandom()});
    pa.op(1'b1, 1'b1, d);
    pa.op(1'b1, 1'b1, ~d);
    @(negedge core_clk);
    cmp(36'(flg[6]), 36'h0);
    pb.op(1'b1, 1'b1, 36'h0);
    pb.op(1'b1, 1'b1, 36'h0);
    @(negedge core_clk);
    cmp(b_dout, d & `MASK_WORD);
    d = 36'({$urandom(), $urandom()});
    pb.op(1'b0, 1'b1, d);
    pa.op(1'b0, 1'b1, 36'h0);
    repeat (2) @(negedge core_clk);
    cmp(a_dout, d & `MASK_WORD);
    chk_st(0);
    base = 36'({$urandom(), $urandom()});
    for (int i = 1; i <= 257; i++) begin
      pa.op(1'b1, 1'b0, base + 36'(i));
      if (i == 2 || i == 3 || i == 251 || i == 252) chk_st(i);
    end
    chk_st(256);
    pb.op(1'b1, 1'b0, 36'h0);
    chk_st(255);
    cmp(b_dout, base + 36'h1);
    for (int j = 0; j < 4; j++) pb.op(1'b1, 1'b0, 36'h0);
    chk_st(251);
    cmp(b_dout, base + 36'h5);
    // Fall-through on the B-to-A queue: word lands unrequested, fill returns to 0
    apb(1'b1, `REG_CTRL, 32'h3, 36'h0);
    d = 36'({$urandom(), $urandom()});
    pb.op(1'b0, 1'b0, d);
    chk_st(251);
    cmp(a_dout, d);
    repeat (3) @(posedge core_clk);
    give_verdict();
  end
endmodule // bidir_fifo_flags_mailbox_tb
`default_nettype wire
